// ===== design/eesq_top.sv
// Contract
// - Write enable then save bit starts upload
// - Upload reads scratchpad until pause or end
// - Non-data bytes except pause/end copied, EEPROM pointer advances
// - Data instruction: store, address, copy range
// - Append checksum after each uploaded block
// - Upload data range reads buffered register copies
// - No conditional processing during upload
// - Load bit starts download until end
// - Auto download after reset if either pin high
// - Pins low skip; codes select condition
// - Four-bit condition, zero runs everything
// - Nonzero field overrides pin-latched condition
// - Codes B1..BF tag conditions 1..15
// - Null condition clears whole tag board
// - Condition and end instructions always run
// - Execute while active condition tagged or no tags set
// - Byte count is instruction plus one
// - Download checks checksums of unskipped blocks, sets fault/complete
// - Pause resets scratch pointer, keeps EEPROM
// - End resets pointers, then idle
`timescale 1ns/1ps
`default_nettype none
module eesq_top #(
    parameter int EE_AW = eesq_pkg::EE_ADDR_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic softReset,
    input wire logic setupSelectPinHigh,
    input wire logic setupSelectPinLow,
    input wire logic [eesq_pkg::REG_ADDR_W-1:0] regAddr,
    input wire logic [eesq_pkg::REG_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [eesq_pkg::REG_DATA_W-1:0] regRdata,
    output logic mapRd,
    output logic [15:0] mapRdAddr,
    output logic mapBufferedSel,
    input wire logic [7:0] mapRdata,
    output logic mapWr,
    output logic [15:0] mapWrAddr,
    output logic [7:0] mapWdata,
    output logic eeRd,
    output logic [EE_AW-1:0] eeRdAddr,
    input wire logic [7:0] eeRdata,
    output logic eeWr,
    output logic [EE_AW-1:0] eeWrAddr,
    output logic [7:0] eeWdata,
    output logic actionStrobe,
    output logic [7:0] actionCode,
    output logic busy
);
    import eesq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    eesq_state_t state_reg, state_next;
    eesq_phase_t phase_reg, phase_next;
    logic upload_reg, upload_next;
    logic [SCRATCH_IDX_W-1:0] spPtr_reg, spPtr_next;
    logic [EE_AW-1:0] eePtr_reg, eePtr_next;
    logic [15:0] target_reg, target_next;
    logic [8:0] count_reg, count_next;
    logic skip_reg, skip_next;
    logic writeEn_reg, writeEn_next;
    logic [COND_W-1:0] cond_reg, cond_next;
    logic complete_reg, complete_next;
    logic fault_reg, fault_next;
    logic [PIN_COND_W-1:0] pinCond_reg, pinCond_next;
    logic latched_reg, latched_next;
    logic autoPend_reg, autoPend_next;
    logic [7:0] rdata_reg, rdata_next;
    logic eeWr_reg, eeWr_next;
    logic [EE_AW-1:0] eeWrAddr_reg, eeWrAddr_next;
    logic [7:0] eeWdata_reg, eeWdata_next;
    logic mapWr_reg, mapWr_next;
    logic [15:0] mapWrAddr_reg, mapWrAddr_next;
    logic [7:0] mapWdata_reg, mapWdata_next;
    logic act_reg, act_next;
    logic [7:0] actCode_reg, actCode_next;

    logic saveCmd, loadCmd;
    logic [7:0] inByte;
    logic csClear, csAdd;
    logic [7:0] csSum;
    logic tagClear, tagSet;
    logic execOk;
    logic [COND_W-1:0] activeCondition;

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    eesq_checksum #(.W(8)) u_checksum (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .clear(csClear),
        .add(csAdd),
        .dataIn(inByte),
        .sum(csSum)
    );

    eesq_cond_unit u_cond (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .condField(cond_reg),
        .pinLatchedCondition(pinCond_reg),
        .tagClear(tagClear),
        .tagSet(tagSet),
        .tagIndex(inByte[COND_W-1:0]),
        .execOk(execOk),
        .activeCondition(activeCondition)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register port and strap capture
    assign saveCmd = regWr && (regAddr == ADDR_SAVE) &&
        regWdata[BIT_SAVE] && writeEn_reg;
    assign loadCmd = regWr && (regAddr == ADDR_LOAD) &&
        regWdata[BIT_LOAD];

    always_comb begin
        writeEn_next = writeEn_reg;
        cond_next = cond_reg;
        pinCond_next = pinCond_reg;
        latched_next = latched_reg;
        rdata_next = 8'h00;
        if (regWr && regAddr == ADDR_WRITE_EN) begin
            writeEn_next = regWdata[BIT_WRITE_EN];
        end
        if (regWr && regAddr == ADDR_COND) begin
            cond_next = regWdata[COND_W-1:0];
        end
        // Pins caught after power-up, hard or soft reset
        if (!latched_reg || softReset) begin
            pinCond_next = {setupSelectPinHigh, setupSelectPinLow};
            latched_next = 1'b1;
        end
        // Command bits read back zero: self-clearing
        if (regRd) begin
            case (regAddr)
                ADDR_WRITE_EN: rdata_next[BIT_WRITE_EN] = writeEn_reg;
                ADDR_COND: rdata_next[COND_W-1:0] = cond_reg;
                ADDR_STATUS: begin
                    rdata_next[BIT_BUSY] = busy;
                    rdata_next[BIT_COMPLETE] = complete_reg;
                    rdata_next[BIT_FAULT] = fault_reg;
                end
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            writeEn_reg <= RST_WRITE_EN;
            cond_reg <= RST_COND;
            pinCond_reg <= '0;
            latched_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else if (ce) begin
            writeEn_reg <= writeEn_next;
            cond_reg <= cond_next;
            pinCond_reg <= pinCond_next;
            latched_reg <= latched_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    assign busy = (state_reg != ST_IDLE);
    assign inByte = upload_reg ? mapRdata : eeRdata;

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        upload_next = upload_reg;
        spPtr_next = spPtr_reg;
        eePtr_next = eePtr_reg;
        target_next = target_reg;
        count_next = count_reg;
        skip_next = skip_reg;
        complete_next = complete_reg;
        fault_next = fault_reg;
        autoPend_next = autoPend_reg;
        eeWr_next = 1'b0;
        eeWrAddr_next = eeWrAddr_reg;
        eeWdata_next = eeWdata_reg;
        mapWr_next = 1'b0;
        mapWrAddr_next = mapWrAddr_reg;
        mapWdata_next = mapWdata_reg;
        act_next = 1'b0;
        actCode_next = actCode_reg;
        csClear = 1'b0;
        csAdd = 1'b0;
        tagClear = 1'b0;
        tagSet = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                phase_next = PH_INS;
                if (saveCmd) begin
                    upload_next = 1'b1;
                    spPtr_next = '0;
                    state_next = ST_FETCH;
                end else if (loadCmd ||
                        (autoPend_reg && pinCond_reg != '0)) begin
                    upload_next = 1'b0;
                    tagClear = 1'b1;
                    complete_next = 1'b0;
                    fault_next = 1'b0;
                    autoPend_next = 1'b0;
                    state_next = ST_FETCH;
                end else if (latched_reg) begin
                    autoPend_next = 1'b0;
                end
            end
            ST_FETCH: state_next = ST_EXEC;
            ST_EXEC: begin
                state_next = ST_FETCH;
                eeWrAddr_next = eePtr_reg;
                eeWdata_next = inByte;
                case (phase_reg)
                    PH_INS: begin
                        count_next = 9'({1'b0, inByte} + COUNT_OFFSET);
                        csClear = 1'b1;
                        if (upload_reg) begin
                            if (inByte == INS_PAUSE) begin
                                spPtr_next = '0;
                                state_next = ST_IDLE;
                            end else if (inByte == INS_END) begin
                                spPtr_next = '0;
                                eePtr_next = '0;
                                state_next = ST_IDLE;
                            end else begin
                                // Condition codes copied as-is
                                eeWr_next = 1'b1;
                                eePtr_next = EE_AW'(eePtr_reg + 1'b1);
                                spPtr_next = SCRATCH_IDX_W'(spPtr_reg + 1'b1);
                                if (eesq_is_data(inByte)) begin
                                    phase_next = PH_ADH;
                                end
                            end
                        end else begin
                            eePtr_next = EE_AW'(eePtr_reg + 1'b1);
                            if (inByte == INS_END) begin
                                eePtr_next = '0;
                                complete_next = !fault_reg;
                                state_next = ST_IDLE;
                            end else if (eesq_is_cond(inByte)) begin
                                tagClear = (inByte == INS_COND_NULL);
                                tagSet = (inByte != INS_COND_NULL);
                            end else if (eesq_is_data(inByte)) begin
                                skip_next = !execOk;
                                phase_next = PH_ADH;
                            end else begin
                                act_next = execOk;
                                actCode_next = inByte;
                            end
                        end
                    end
                    PH_ADH, PH_ADL: begin
                        if (phase_reg == PH_ADH) begin
                            target_next[15:8] = inByte;
                            phase_next = PH_ADL;
                        end else begin
                            target_next[7:0] = inByte;
                            phase_next = PH_DAT;
                        end
                        eePtr_next = EE_AW'(eePtr_reg + 1'b1);
                        if (upload_reg) begin
                            eeWr_next = 1'b1;
                            spPtr_next = SCRATCH_IDX_W'(spPtr_reg + 1'b1);
                        end
                    end
                    PH_DAT: begin
                        csAdd = 1'b1;
                        target_next = 16'(target_reg + 16'h0001);
                        count_next = 9'(count_reg - 9'h001);
                        eePtr_next = EE_AW'(eePtr_reg + 1'b1);
                        if (upload_reg) begin
                            eeWr_next = 1'b1;
                        end else begin
                            mapWr_next = !skip_reg;
                            mapWrAddr_next = target_reg;
                            mapWdata_next = inByte;
                        end
                        if (count_reg == 9'h001) begin
                            phase_next = PH_SUM;
                        end
                    end
                    PH_SUM: begin
                        eePtr_next = EE_AW'(eePtr_reg + 1'b1);
                        phase_next = PH_INS;
                        if (upload_reg) begin
                            eeWr_next = 1'b1;
                            eeWdata_next = csSum;
                        end else if (!skip_reg && csSum != inByte) begin
                            fault_next = 1'b1;
                        end
                    end
                    default: phase_next = PH_INS;
                endcase
            end
            default: state_next = ST_IDLE;
        endcase
        // Armed after the idle decision so a soft reset is not lost
        if (!latched_reg || softReset) begin
            autoPend_next = 1'b1;
        end
        if (softReset) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            phase_reg <= PH_INS;
            upload_reg <= 1'b0;
            spPtr_reg <= '0;
            eePtr_reg <= '0;
            target_reg <= 16'h0000;
            count_reg <= 9'h000;
            skip_reg <= 1'b0;
            complete_reg <= 1'b0;
            fault_reg <= 1'b0;
            autoPend_reg <= 1'b0;
            eeWr_reg <= 1'b0;
            eeWrAddr_reg <= '0;
            eeWdata_reg <= 8'h00;
            mapWr_reg <= 1'b0;
            mapWrAddr_reg <= 16'h0000;
            mapWdata_reg <= 8'h00;
            act_reg <= 1'b0;
            actCode_reg <= 8'h00;
        end else if (ce) begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            upload_reg <= upload_next;
            spPtr_reg <= spPtr_next;
            eePtr_reg <= eePtr_next;
            target_reg <= target_next;
            count_reg <= count_next;
            skip_reg <= skip_next;
            complete_reg <= complete_next;
            fault_reg <= fault_next;
            autoPend_reg <= autoPend_next;
            eeWr_reg <= eeWr_next;
            eeWrAddr_reg <= eeWrAddr_next;
            eeWdata_reg <= eeWdata_next;
            mapWr_reg <= mapWr_next;
            mapWrAddr_reg <= mapWrAddr_next;
            mapWdata_reg <= mapWdata_next;
            act_reg <= act_next;
            actCode_reg <= actCode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign regRdata = rdata_reg;
    assign mapRd = ce && (state_reg == ST_FETCH) && upload_reg;
    assign mapRdAddr = (phase_reg == PH_DAT) ? target_reg :
        16'(SCRATCH_BASE + spPtr_reg);
    assign mapBufferedSel = mapRd && (phase_reg == PH_DAT);
    assign mapWr = mapWr_reg;
    assign mapWrAddr = mapWrAddr_reg;
    assign mapWdata = mapWdata_reg;
    assign eeRd = ce && (state_reg == ST_FETCH) && !upload_reg;
    assign eeRdAddr = eePtr_reg;
    assign eeWr = eeWr_reg;
    assign eeWrAddr = eeWrAddr_reg;
    assign eeWdata = eeWdata_reg;
    assign actionStrobe = act_reg;
    assign actionCode = actCode_reg;
endmodule
`default_nettype wire

// ===== design/eesq_pkg.sv
package eesq_pkg;

    // Register port
    localparam int REG_ADDR_W = 16;
    localparam int REG_DATA_W = 8;
    localparam logic [15:0] ADDR_WRITE_EN = 16'h0E00;
    localparam logic [15:0] ADDR_COND = 16'h0E01;
    localparam logic [15:0] ADDR_SAVE = 16'h0E02;
    localparam logic [15:0] ADDR_LOAD = 16'h0E03;
    localparam logic [15:0] ADDR_STATUS = 16'h0E04;
    localparam logic [15:0] SCRATCH_BASE = 16'h0E10;

    // Field positions
    localparam int BIT_WRITE_EN = 0;
    localparam int BIT_SAVE = 0;
    localparam int BIT_LOAD = 1;
    localparam int BIT_BUSY = 0;
    localparam int BIT_COMPLETE = 1;
    localparam int BIT_FAULT = 2;
    localparam int COND_W = 4;
    localparam int PIN_COND_W = 2;

    // Values after reset
    localparam logic RST_WRITE_EN = 1'b0;
    localparam logic [3:0] RST_COND = 4'h0;

    // Instruction codes
    localparam logic [7:0] INS_DATA_LAST = 8'h7F;
    localparam logic [7:0] INS_COND_NULL = 8'hB0;
    localparam logic [7:0] INS_COND_LAST = 8'hBF;
    localparam logic [7:0] INS_PAUSE = 8'hFE;
    localparam logic [7:0] INS_END = 8'hFF;
    localparam logic [8:0] COUNT_OFFSET = 9'h001;

    // Array sizes
    localparam int EE_ADDR_W = 11;
    localparam int SCRATCH_IDX_W = 8;

    // Host wait between transfers, enforced by software
    localparam int GAP_NS = 10000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int GAP_CYCLES = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_EXEC = 3'b100
    } eesq_state_t;

    typedef enum logic [4:0] {
        PH_INS = 5'b00001,
        PH_ADH = 5'b00010,
        PH_ADL = 5'b00100,
        PH_DAT = 5'b01000,
        PH_SUM = 5'b10000
    } eesq_phase_t;

    function automatic logic eesq_is_data(input logic [7:0] b);
        return b <= INS_DATA_LAST;
    endfunction

    function automatic logic eesq_is_cond(input logic [7:0] b);
        return (b >= INS_COND_NULL) && (b <= INS_COND_LAST);
    endfunction

endpackage

// ===== design/eesq_checksum.sv
`timescale 1ns/1ps
`default_nettype none
module eesq_checksum #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic clear,
    input wire logic add,
    input wire logic [W-1:0] dataIn,
    output logic [W-1:0] sum
);
    logic [W-1:0] sum_reg;
    logic [W-1:0] sum_next;

    // Modulo sum of block data bytes
    always_comb begin
        sum_next = sum_reg;
        if (clear) begin
            sum_next = '0;
        end else if (add) begin
            sum_next = W'(sum_reg + dataIn);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sum_reg <= '0;
        end else if (ce) begin
            sum_reg <= sum_next;
        end
    end

    assign sum = sum_reg;
endmodule
`default_nettype wire

// ===== design/eesq_cond_unit.sv
`timescale 1ns/1ps
`default_nettype none
module eesq_cond_unit (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [eesq_pkg::COND_W-1:0] condField,
    input wire logic [eesq_pkg::PIN_COND_W-1:0] pinLatchedCondition,
    input wire logic tagClear,
    input wire logic tagSet,
    input wire logic [eesq_pkg::COND_W-1:0] tagIndex,
    output logic execOk,
    output logic [eesq_pkg::COND_W-1:0] activeCondition
);
    import eesq_pkg::*;

    logic [15:0] tags_reg;
    logic [15:0] tags_next;

    always_comb begin
        tags_next = tags_reg;
        if (tagClear) begin
            tags_next = 16'h0000;
        end else if (tagSet) begin
            tags_next[tagIndex] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tags_reg <= 16'h0000;
        end else if (ce) begin
            tags_reg <= tags_next;
        end
    end

    // Register field wins when nonzero
    assign activeCondition = (condField != '0) ? condField :
        {{(COND_W - PIN_COND_W){1'b0}}, pinLatchedCondition};

    assign execOk = (activeCondition == '0) || (tags_reg == 16'h0000) ||
        tags_reg[activeCondition];
endmodule
`default_nettype wire

// ===== bench/eesq_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module eesq_top_sva
    import eesq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic mapRd,
    input wire logic [15:0] mapRdAddr,
    input wire logic mapBufferedSel,
    input wire logic mapWr,
    input wire logic eeRd,
    input wire logic eeWr,
    input wire logic actionStrobe,
    input wire logic busy
);
    logic weShadow;
    logic saveWr;
    assign saveWr = regWr && regAddr == ADDR_SAVE && regWdata[BIT_SAVE];
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            weShadow <= 1'b0;
        end else if (regWr && regAddr == ADDR_WRITE_EN) begin
            weShadow <= regWdata[BIT_WRITE_EN];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_save_start: assert property (
        saveWr && weShadow && !busy |=> busy && mapRd && mapRdAddr == SCRATCH_BASE)
        else $error("save did not start at scratchpad base");
    chk_save_refused: assert property (
        saveWr && !weShadow && !busy |=> !busy)
        else $error("save started without write enable");
    chk_load_start: assert property (
        regWr && regAddr == ADDR_LOAD && regWdata[BIT_LOAD] && !busy
        |=> busy && eeRd)
        else $error("load did not start");
    chk_cmd_reads_zero: assert property (
        regRd && (regAddr == ADDR_SAVE || regAddr == ADDR_LOAD)
        |=> regRdata == 8'h00)
        else $error("command bit did not read back zero");
    chk_one_source: assert property (!(mapRd && eeRd))
        else $error("map and eeprom fetched together");
    chk_one_sink: assert property (!(mapWr && eeWr))
        else $error("map and eeprom written together");
    chk_idle_quiet: assert property (
        !busy && !$past(busy) && !$past(busy, 2)
        |-> !eeWr && !mapWr && !actionStrobe)
        else $error("activity while idle");
    chk_fetch_busy: assert property (mapRd || eeRd |-> busy)
        else $error("fetch outside a transfer");
    chk_buffered: assert property (mapBufferedSel |-> mapRd && !eeRd)
        else $error("buffered select without map read");
endmodule
bind eesq_top eesq_top_sva chk (.clk_sys(clk_sys), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .mapRd(mapRd), .mapRdAddr(mapRdAddr),
    .mapBufferedSel(mapBufferedSel), .mapWr(mapWr), .eeRd(eeRd),
    .eeWr(eeWr), .actionStrobe(actionStrobe), .busy(busy));
`default_nettype wire

// ===== bench/eesq_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module eesq_far_model #(
    parameter int EE_AW = 11
) (
    input wire logic clk_sys,
    input wire logic mapRd,
    input wire logic [15:0] mapRdAddr,
    output logic [7:0] mapRdata,
    input wire logic mapWr,
    input wire logic [15:0] mapWrAddr,
    input wire logic [7:0] mapWdata,
    input wire logic eeRd,
    input wire logic [EE_AW-1:0] eeRdAddr,
    output logic [7:0] eeRdata,
    input wire logic eeWr,
    input wire logic [EE_AW-1:0] eeWrAddr,
    input wire logic [7:0] eeWdata
);
    logic [7:0] mapMem [0:65535];
    logic [7:0] eeMem [0:(1<<EE_AW)-1];
    // Data valid one cycle only, then scrambled
    always @(posedge clk_sys) begin
        mapRdata <= mapRd ? mapMem[mapRdAddr] : ~mapRdata;
        eeRdata <= eeRd ? eeMem[eeRdAddr] : ~eeRdata;
        if (mapWr) begin
            mapMem[mapWrAddr] <= mapWdata;
        end
        if (eeWr) begin
            eeMem[eeWrAddr] <= eeWdata;
        end
    end
endmodule
`default_nettype wire

// ===== bench/eeprom_setup_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_setup_sequencer_tb import eesq_pkg::*;;
    logic clk_sys, rst, softReset, pinHigh, pinLow, regWr, regRd, busy;
    logic [15:0] regAddr, mapRdAddr, mapWrAddr;
    logic [7:0] regWdata, regRdata, mapRdata, mapWdata, eeRdata, eeWdata;
    logic mapRd, mapBufferedSel, mapWr, eeRd, eeWr, actionStrobe;
    logic [10:0] eeRdAddr, eeWrAddr;
    logic [7:0] actionCode, lastAct;
    logic [63:0] eeExp = 64'hB101123411223380;
    int err_count = 0;
    int samples_checked = 0;
    int actCount = 0;
    eesq_top dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
        .softReset(softReset), .setupSelectPinHigh(pinHigh),
        .setupSelectPinLow(pinLow), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .mapRd(mapRd),
        .mapRdAddr(mapRdAddr), .mapBufferedSel(mapBufferedSel),
        .mapRdata(mapRdata), .mapWr(mapWr), .mapWrAddr(mapWrAddr),
        .mapWdata(mapWdata), .eeRd(eeRd), .eeRdAddr(eeRdAddr),
        .eeRdata(eeRdata), .eeWr(eeWr), .eeWrAddr(eeWrAddr),
        .eeWdata(eeWdata), .actionStrobe(actionStrobe),
        .actionCode(actionCode), .busy(busy));
    eesq_far_model #(.EE_AW(11)) mdl (.clk_sys(clk_sys), .mapRd(mapRd),
        .mapRdAddr(mapRdAddr), .mapRdata(mapRdata), .mapWr(mapWr),
        .mapWrAddr(mapWrAddr), .mapWdata(mapWdata), .eeRd(eeRd),
        .eeRdAddr(eeRdAddr), .eeRdata(eeRdata), .eeWr(eeWr),
        .eeWrAddr(eeWrAddr), .eeWdata(eeWdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] e,
                         input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic regWrite(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic regRead(input logic [15:0] a, input logic [7:0] e,
                           input string what);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        check(what, e, regRdata);
    endtask
    task automatic runDone();
        int n;
        n = 0;
        #1;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("busy end", 8'h00, {7'h0, busy});
        repeat (GAP_CYCLES) @(posedge clk_sys);
    endtask
    task automatic scratch(input logic [39:0] s);
        for (int i = 0; i < 5; i++) begin
            mdl.mapMem[SCRATCH_BASE + 16'(i)] = s[39-8*i -: 8];
        end
    endtask
    always @(posedge clk_sys) begin
        if (actionStrobe === 1'b1) begin
            actCount++;
            lastAct = actionCode;
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #1000000;
        err_count++;
        conclude();
    end
    initial begin
        {rst, softReset, pinHigh, pinLow, regWr, regRd} = 6'b100000;
        regAddr = 16'h0000;
        regWdata = 8'h00;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 check("auto skip", 8'h00, {7'h0, busy});
        mdl.mapMem[16'h1234] = 8'h11;
        mdl.mapMem[16'h1235] = 8'h22;
        regRead(ADDR_WRITE_EN, 8'h00, "we reset");
        regRead(16'h0E05, 8'h00, "unmapped");
        scratch(40'hB1FE000000);
        regWrite(ADDR_SAVE, 8'h01);
        #1 check("save refused", 8'h00, {7'h0, busy});
        regWrite(ADDR_WRITE_EN, 8'h01);
        regWrite(ADDR_SAVE, 8'h01);
        runDone();
        scratch(40'h01123480FF);
        regWrite(ADDR_SAVE, 8'h01);
        runDone();
        for (int i = 0; i < 8; i++) begin
            check("ee byte", eeExp[63-8*i -: 8], mdl.eeMem[i]);
        end
        regRead(ADDR_SAVE, 8'h00, "save clear");
        mdl.eeMem[8] = INS_END;
        mdl.mapMem[16'h1234] = 8'h00;
        regWrite(ADDR_COND, 8'h02);
        regRead(ADDR_COND, 8'h02, "cond");
        regWrite(ADDR_LOAD, 8'h02);
        runDone();
        check("skip data", 8'h00, mdl.mapMem[16'h1234]);
        check("skip act", 8'h00, 8'(actCount));
        regWrite(ADDR_COND, 8'h01);
        regWrite(ADDR_LOAD, 8'h02);
        regWrite(ADDR_LOAD, 8'h02);
        runDone();
        check("map lo", 8'h11, mdl.mapMem[16'h1234]);
        check("map hi", 8'h22, mdl.mapMem[16'h1235]);
        check("act cnt", 8'h01, 8'(actCount));
        check("act code", 8'h80, lastAct);
        regRead(ADDR_STATUS, 8'h02, "complete");
        mdl.mapMem[16'h1234] = 8'h00;
        regWrite(ADDR_COND, 8'h00);
        @(posedge clk_sys);
        softReset <= 1'b1;
        pinLow <= 1'b1;
        @(posedge clk_sys);
        softReset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 check("auto start", 8'h01, {7'h0, busy});
        runDone();
        check("auto data", 8'h11, mdl.mapMem[16'h1234]);
        mdl.eeMem[6] = 8'h34;
        regWrite(ADDR_LOAD, 8'h02);
        runDone();
        regRead(ADDR_STATUS, 8'h04, "fault");
        mdl.eeMem[0] = INS_COND_NULL;
        mdl.eeMem[6] = 8'h33;
        mdl.mapMem[16'h1234] = 8'h00;
        regWrite(ADDR_COND, 8'h02);
        regWrite(ADDR_LOAD, 8'h02);
        runDone();
        check("null cond", 8'h11, mdl.mapMem[16'h1234]);
        regRead(ADDR_STATUS, 8'h02, "fault cleared");
        conclude();
    end
endmodule
`default_nettype wire
